/* File: src/mpct_top.sv */
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module mpct_top
  import mpct_pkg::*;
#(
  parameter int WD_CYCLES = WD_CYCLES_DEF,
  parameter int DEPTH = 16
)(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [N_PORTS-1:0][PORT_W-1:0] i_mot_in,
  output logic [N_PORTS-1:0][PORT_W-1:0] o_mot_out,
  output logic [PORT_W-1:0] o_mot3_oe,
  output logic [WAVE_W-1:0] o_wave,
  output mpct_lines_s o_lines
);
  localparam int PW = $clog2(DEPTH);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [N_PORTS-1:0][PORT_W-1:0] in_s1_q, in_s2_q;
  genvar gp;
  generate
    for (gp = 0; gp < N_PORTS; gp++)
    begin : g_sync
      always_ff @(posedge i_clk_sys or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          in_s1_q[gp] <= 8'h00;
          in_s2_q[gp] <= 8'h00;
        end
        else
        begin
          in_s1_q[gp] <= i_mot_in[gp];
          in_s2_q[gp] <= in_s1_q[gp];
        end
      end
    end
  endgenerate

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= A_WAVE_STAT);
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [N_PORTS-1:0][PORT_W-1:0] out_q, out_d;
  logic [N_PORTS-1:0][31:0] wd_q, wd_d;
  logic [N_PORTS-1:0] wd_en_q, wd_en_d, err_q, err_d, expire;
  logic [31:0] pmask_q, pmask_d;
  logic [PORT_W-1:0] oe_q, oe_d;
  logic [DIV_W-1:0] div_q, div_d, dcnt_q, dcnt_d, div_eff;
  logic [REP_W-1:0] rep_q, rep_d, left_q, left_d;
  logic [DEPTH-1:0][WAVE_W-1:0] mem_q, mem_d;
  logic [PW:0] cnt_q, cnt_d;
  logic [PW-1:0] rd_q, rd_d;
  logic [WAVE_W-1:0] wave_q, wave_d;
  mpct_wave_e st_q, st_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr, rd, tick, last;
  logic [31:0] wdat;

  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_wready = s_axi_awready;
  assign s_axi_arready = !rvalid_q;
  assign wr = s_axi_awready;
  assign rd = s_axi_arvalid && !rvalid_q;
  assign div_eff = (div_q < DIV_MIN) ? DIV_MIN : div_q;
  assign tick = (dcnt_q == div_eff - 1'b1);
  assign last = ({1'b0, rd_q} == cnt_q - 1'b1);

  // Byte-lane merge of write data against the addressed register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int b = 0; b < 4; b++)
      merge[8*b +: 8] = be[b] ? nw[8*b +: 8] : old[8*b +: 8];
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    out_d = out_q;
    wd_d = wd_q;
    wd_en_d = wd_en_q;
    err_d = err_q;
    pmask_d = pmask_q;
    oe_d = oe_q;
    div_d = div_q;
    rep_d = rep_q;
    left_d = left_q;
    mem_d = mem_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    wave_d = wave_q;
    st_d = st_q;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !s_axi_rready;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    wdat = 32'h00000000;
    dcnt_d = tick ? '0 : dcnt_q + 1'b1;
    // Watchdogs run only while enabled and some power bit is on
    for (int p = 0; p < N_PORTS; p++)
    begin
      expire[p] = 1'b0;
      if (wd_en_q[p] && |(out_q[p] & pmask_q[8*p +: 8]))
      begin
        if (wd_q[p] == 32'(WD_CYCLES - 1))
        begin
          expire[p] = 1'b1;
          wd_d[p] = '0;
          out_d[p] = out_q[p] & ~pmask_q[8*p +: 8];
        end
        else
          wd_d[p] = wd_q[p] + 32'h00000001;
      end
      else
        wd_d[p] = '0;
    end
    // Waveform playback, one word per divided tick
    case (st_q)
      WV_IDLE:
      begin
        rd_d = '0;
      end
      WV_RUN:
      begin
        if (tick)
        begin
          wave_d = mem_q[rd_q];
          if (!last)
            rd_d = rd_q + 1'b1;
          else if (left_q != '0)
          begin
            rd_d = '0;
            left_d = left_q - 1'b1;
          end
          else
            st_d = WV_IDLE;
        end
      end
      default:
        st_d = WV_IDLE;
    endcase
    if (wr)
    begin
      bvalid_d = 1'b1;
      bresp_d = mapped(s_axi_awaddr) && s_axi_awaddr != A_WAVE_STAT
                ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_awaddr)
        A_MOT_OUT0, 8'h04, 8'h08, 8'h0C:
        begin
          wdat = merge({24'h000000, out_q[s_axi_awaddr[3:2]]}, s_axi_wdata,
                       s_axi_wstrb);
          out_d[s_axi_awaddr[3:2]] = wdat[7:0];
          wd_d[s_axi_awaddr[3:2]] = '0;
        end
        A_WD_EN:
        begin
          wdat = merge({28'h0000000, wd_en_q}, s_axi_wdata, s_axi_wstrb);
          wd_en_d = wdat[3:0];
        end
        A_WD_ERR:
        begin
          if (s_axi_wstrb[0])
            err_d = err_q & ~s_axi_wdata[3:0];
        end
        A_PWR_MASK:
          pmask_d = merge(pmask_q, s_axi_wdata, s_axi_wstrb);
        A_BIDIR_OE:
        begin
          if (s_axi_wstrb[0])
            oe_d = s_axi_wdata[7:0];
        end
        A_DIVISOR:
        begin
          wdat = merge({16'h0000, div_q}, s_axi_wdata, s_axi_wstrb);
          div_d = wdat[15:0];
        end
        A_REPEAT:
        begin
          wdat = merge({16'h0000, rep_q}, s_axi_wdata, s_axi_wstrb);
          rep_d = wdat[15:0];
        end
        A_WAVE_CTRL:
        begin
          if (s_axi_wstrb[0] && st_q == WV_IDLE)
          begin
            if (s_axi_wdata[CTRL_FLUSH_BIT])
              cnt_d = '0;
            else if (s_axi_wdata[CTRL_RUN_BIT] && cnt_q != '0)
            begin
              st_d = WV_RUN;
              left_d = rep_q;
              rd_d = '0;
            end
          end
          else if (s_axi_wstrb[0] && !s_axi_wdata[CTRL_RUN_BIT])
            st_d = WV_IDLE;
        end
        A_WAVE_PUSH:
        begin
          if (st_q == WV_IDLE && cnt_q < (PW+1)'(DEPTH))
          begin
            mem_d[cnt_q[PW-1:0]] = s_axi_wdata;
            cnt_d = cnt_q + 1'b1;
          end
        end
        A_BYPASS:
          wave_d = merge(wave_q, s_axi_wdata, s_axi_wstrb);
        default:
          wdat = 32'h00000000;
      endcase
    end
    // Hardware set wins over a same-cycle software clear
    err_d = err_d | expire;
    if (rd)
    begin
      rvalid_d = 1'b1;
      rresp_d = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_d = 32'h00000000;
      case (s_axi_araddr)
        A_MOT_OUT0, 8'h04, 8'h08, 8'h0C:
          rdata_d = {24'h000000, out_q[s_axi_araddr[3:2]]};
        A_MOT_IN0, 8'h14, 8'h18, 8'h1C:
          rdata_d = {24'h000000, in_s2_q[s_axi_araddr[3:2]]};
        A_WD_EN:
          rdata_d = {28'h0000000, wd_en_q};
        A_WD_ERR:
          rdata_d = {28'h0000000, err_q};
        A_PWR_MASK:
          rdata_d = pmask_q;
        A_BIDIR_OE:
          rdata_d = {24'h000000, oe_q};
        A_DIVISOR:
          rdata_d = {16'h0000, div_q};
        A_REPEAT:
          rdata_d = {16'h0000, rep_q};
        A_WAVE_CTRL:
          rdata_d = {31'h00000000, st_q == WV_RUN};
        A_BYPASS:
          rdata_d = wave_q;
        A_WAVE_STAT:
          rdata_d = {16'(left_q), 16'(cnt_q)};
        default:
          rdata_d = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      out_q <= '0;
      wd_q <= '0;
      wd_en_q <= '0;
      err_q <= '0;
      pmask_q <= PWR_MASK_RST;
      oe_q <= 8'h00;
      div_q <= DIV_MIN;
      dcnt_q <= '0;
      rep_q <= '0;
      left_q <= '0;
      mem_q <= '0;
      cnt_q <= '0;
      rd_q <= '0;
      wave_q <= '0;
      st_q <= WV_IDLE;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      out_q <= out_d;
      wd_q <= wd_d;
      wd_en_q <= wd_en_d;
      err_q <= err_d;
      pmask_q <= pmask_d;
      oe_q <= oe_d;
      div_q <= div_d;
      dcnt_q <= dcnt_d;
      rep_q <= rep_d;
      left_q <= left_d;
      mem_q <= mem_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      wave_q <= wave_d;
      st_q <= st_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_mot_out = out_q;
  assign o_mot3_oe = oe_q;
  assign o_wave = wave_q;
  assign o_lines.convert = wave_q[LINE_CONVERT];
  assign o_lines.select = wave_q[LINE_SELECT];
  assign o_lines.capture = wave_q[LINE_CAPTURE];
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence s_expire0;
    expire[0] && !wr;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  a_wd_cut_power: assert property (s_expire0 |=>
    (o_mot_out[0] & $past(pmask_q[7:0])) == 8'h00)
    else $error("watchdog did not cut port 0 power");
  a_wd_err_set: assert property (expire[0] |=> err_q[0])
    else $error("watchdog error bit not set");
  a_err_sticky: assert property (err_q[0] && !wr |=> err_q[0])
    else $error("error bit dropped without clear");
  a_wd_restart: assert property ((s_wr_take and s_axi_awaddr == A_MOT_OUT0)
    |=> wd_q[0] == '0)
    else $error("port write did not restart watchdog");
  a_tick_spacing: assert property (tick |=> !tick [*2])
    else $error("word rate above limit");
  a_repeat_wrap: assert property (st_q == WV_RUN && tick && last
    && left_q != '0 |=> rd_q == '0 && left_q == $past(left_q) - 1'b1)
    else $error("buffer did not retransmit");
  a_run_done: assert property (st_q == WV_RUN && tick && last
    && left_q == '0 && !wr |=> st_q == WV_IDLE)
    else $error("playback did not stop");
  a_bypass_out: assert property ((s_wr_take and s_axi_awaddr == A_BYPASS
    && s_axi_wstrb == 4'hF) |=> o_wave == $past(s_axi_wdata))
    else $error("bypass word not on waveform lines");
  a_lines_split: assert property (o_lines.capture == o_wave[LINE_CAPTURE]
    && o_lines.select == o_wave[LINE_SELECT])
    else $error("split lines differ from waveform");
  a_write_resp: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write not answered");
endmodule
`default_nettype wire

/* File: src/mpct_pkg.sv */
package mpct_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] A_MOT_OUT0 = 8'h00;
  localparam logic [7:0] A_MOT_IN0 = 8'h10;
  localparam logic [7:0] A_WD_EN = 8'h20;
  localparam logic [7:0] A_WD_ERR = 8'h24;
  localparam logic [7:0] A_PWR_MASK = 8'h28;
  localparam logic [7:0] A_BIDIR_OE = 8'h2C;
  localparam logic [7:0] A_DIVISOR = 8'h30;
  localparam logic [7:0] A_REPEAT = 8'h34;
  localparam logic [7:0] A_WAVE_CTRL = 8'h38;
  localparam logic [7:0] A_WAVE_PUSH = 8'h3C;
  localparam logic [7:0] A_BYPASS = 8'h40;
  localparam logic [7:0] A_WAVE_STAT = 8'h44;
  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int N_PORTS = 4;
  localparam int PORT_W = 8;
  localparam int WAVE_W = 32;
  localparam int DIV_W = 16;
  localparam int REP_W = 16;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_FLUSH_BIT = 1;
  localparam int LINE_CONVERT = 0;
  localparam int LINE_SELECT = 1;
  localparam int LINE_CAPTURE = 2;
  localparam logic [31:0] PWR_MASK_RST = 32'hC0C0C0C0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ = 125000;
  localparam int WAVE_MAX_KHZ = 5000;
  // Least divisor so the word rate never exceeds the maximum
  localparam logic [DIV_W-1:0] DIV_MIN =
    DIV_W'((CLK_KHZ + WAVE_MAX_KHZ - 1) / WAVE_MAX_KHZ);
  localparam int WD_TIMEOUT_MS = 2000;
  localparam int WD_CYCLES_DEF = WD_TIMEOUT_MS * (CLK_KHZ / 1000) * 1000;

  typedef enum logic [0:0] {
    WV_IDLE = 1'b0,
    WV_RUN = 1'b1
  } mpct_wave_e;

  typedef struct packed {
    logic convert;
    logic select;
    logic capture;
  } mpct_lines_s;
endpackage

/* File: tb/mpct_far_model.sv */
`timescale 1ns/10ps
`default_nettype none
module mpct_far_model
  import mpct_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [N_PORTS-1:0][PORT_W-1:0] i_mot_out,
  input wire logic [PORT_W-1:0] i_mot3_oe,
  input wire logic [WAVE_W-1:0] i_wave,
  input wire mpct_lines_s i_lines,
  output logic [N_PORTS-1:0][PORT_W-1:0] o_mot_in,
  output logic [15:0] o_last_word,
  output logic [15:0] o_n_cap
);
  logic cap_q;
  // ----------------------------------------
  // Switches and sensor pads
  // ----------------------------------------
  always_comb
  begin
    for (int p = 0; p < N_PORTS - 1; p++)
      o_mot_in[p] = ~i_mot_out[p];
    // Undriven sensor lines sit at the pull-up level
    o_mot_in[3] = (i_mot_out[3] & i_mot3_oe) | ~i_mot3_oe;
  end
  // ----------------------------------------
  // Acquisition input, one word per strobe
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cap_q <= 1'b0;
      o_n_cap <= 16'h0000;
      o_last_word <= 16'h0000;
    end
    else
    begin
      cap_q <= i_lines.capture;
      if (i_lines.capture && !cap_q)
      begin
        o_n_cap <= o_n_cap + 16'h0001;
        o_last_word <= i_wave[31:16];
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import mpct_pkg::*;
  logic clk;
  logic i_rst_n = 1'b0;
  logic [7:0] aw_a = 8'h00;
  logic aw_v = 1'b0;
  logic [31:0] w_d = 32'h00000000;
  logic w_v = 1'b0;
  logic b_r = 1'b0;
  logic [7:0] ar_a = 8'h00;
  logic ar_v = 1'b0;
  logic r_r = 1'b0;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v;
  logic [1:0] b_resp, r_resp;
  logic [31:0] r_d;
  logic [N_PORTS-1:0][PORT_W-1:0] mot_in, mot_out;
  logic [PORT_W-1:0] oe;
  logic [WAVE_W-1:0] wave;
  mpct_lines_s lines;
  logic [15:0] n_cap, last_w;
  int n_fail = 0;
  int comparisons = 0;

  mpct_top #(.WD_CYCLES(50), .DEPTH(16)) dut (.i_clk_sys(clk), .i_rst_n(i_rst_n),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_resp),
    .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
    .s_axi_rready(r_r), .i_mot_in(mot_in), .o_mot_out(mot_out), .o_mot3_oe(oe),
    .o_wave(wave), .o_lines(lines));
  mpct_far_model far (.i_clk(clk), .i_rst_n(i_rst_n), .i_mot_out(mot_out), .i_mot3_oe(oe),
    .i_wave(wave), .i_lines(lines), .o_mot_in(mot_in), .o_last_word(last_w), .o_n_cap(n_cap));

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ok;
    logic [1:0] rs;
    rs = 2'h0;
    @(posedge clk);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    do
    begin
      @(negedge clk);
      ok = aw_rdy && w_rdy;
      @(posedge clk);
    end while (!ok);
    aw_v <= 1'b0;
    w_v <= 1'b0;
    do
    begin
      @(negedge clk);
      ok = b_v;
      rs = b_resp;
      @(posedge clk);
    end while (!ok);
    chk("bresp", er, rs);
    b_r <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    logic ok;
    @(posedge clk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do
    begin
      @(negedge clk);
      ok = ar_rdy;
      @(posedge clk);
    end while (!ok);
    ar_v <= 1'b0;
    do
    begin
      @(negedge clk);
      ok = r_v;
      d = r_d;
      @(posedge clk);
    end while (!ok);
    chk("rresp", er, r_resp);
    r_r <= 1'b0;
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    logic [31:0] rd, prev;
    logic [7:0] v;
    logic [31:0] wv [2];
    int n;
    wv[0] = 32'hABCD0004;
    wv[1] = 32'h12340002;
    repeat (20) @(posedge clk);
    i_rst_n <= 1'b1;
    @(negedge clk);
    chk("mot_out", 32'h00000000, mot_out);
    chk("oe", 32'h00000000, oe);
    axr(A_PWR_MASK, rd, RESP_OKAY);
    chk("pwr_mask", PWR_MASK_RST, rd);
    axr(A_DIVISOR, rd, RESP_OKAY);
    chk("divisor", 32'(DIV_MIN), rd);
    axr(8'h80, rd, RESP_SLVERR);
    chk("unmapped", 32'h00000000, rd);
    axw(A_WAVE_STAT, 32'h00000000, RESP_SLVERR);
    axw(A_BIDIR_OE, 32'h0000000F, RESP_OKAY);
    for (int p = 0; p < N_PORTS; p++)
      axw(A_MOT_OUT0 + 8'(4 * p), 32'(8'h35 + 8'(p)), RESP_OKAY);
    for (int p = 0; p < N_PORTS; p++)
    begin
      v = 8'h35 + 8'(p);
      axr(A_MOT_OUT0 + 8'(4 * p), rd, RESP_OKAY);
      chk("out_rb", 32'(v), rd);
      axr(A_MOT_IN0 + 8'(4 * p), rd, RESP_OKAY);
      chk("in_rb", (p == 3) ? 32'((v & 8'h0F) | 8'hF0) : {24'h000000, ~v}, rd);
    end
    axw(A_WD_EN, 32'h00000003, RESP_OKAY);
    axw(A_MOT_OUT0, 32'h000000C1, RESP_OKAY);
    axw(A_MOT_OUT0 + 8'h04, 32'h000000C2, RESP_OKAY);
    axw(A_MOT_OUT0 + 8'h08, 32'h000000C3, RESP_OKAY);
    repeat (35) @(posedge clk);
    axw(A_MOT_OUT0 + 8'h04, 32'h000000C2, RESP_OKAY);
    repeat (35) @(posedge clk);
    @(negedge clk);
    chk("wd_cut", 32'h00000001, mot_out[0]);
    chk("wd_restart", 32'h000000C2, mot_out[1]);
    chk("wd_off", 32'h000000C3, mot_out[2]);
    axr(A_WD_ERR, rd, RESP_OKAY);
    chk("wd_err", 32'h00000001, rd);
    axw(A_WD_EN, 32'h00000000, RESP_OKAY);
    axw(A_WD_ERR, 32'h0000000F, RESP_OKAY);
    axr(A_WD_ERR, rd, RESP_OKAY);
    chk("wd_clr", 32'h00000000, rd);
    chk("pwr_stays", 32'h00000001, mot_out[0]);
    axw(A_MOT_OUT0 + 8'h08, 32'h00000003, RESP_OKAY);
    chk("pwr_off", 32'h00000003, mot_out[2]);
    axw(A_BYPASS, 32'h00000001, RESP_OKAY);
    @(negedge clk);
    chk("bypass", 32'h00000001, wave);
    chk("lines_bp", 32'h00000004, lines);
    axw(A_DIVISOR, 32'h00000001, RESP_OKAY);
    axw(A_WAVE_PUSH, wv[0], RESP_OKAY);
    axw(A_WAVE_PUSH, wv[1], RESP_OKAY);
    axw(A_REPEAT, 32'h00000001, RESP_OKAY);
    axw(A_WAVE_CTRL, 32'h00000001, RESP_OKAY);
    prev = 32'h00000001;
    @(negedge clk);
    for (int i = 0; i < 4; i++)
    begin
      n = 0;
      while (wave === prev && n < 1000)
      begin
        @(negedge clk);
        n++;
      end
      if (i > 0)
        chk("spacing", 32'(DIV_MIN), n);
      chk("wave", wv[i % 2], wave);
      chk("lines", {wv[i % 2][0], wv[i % 2][1], wv[i % 2][2]}, lines);
      prev = wave;
    end
    repeat (3 * DIV_MIN) @(negedge clk);
    chk("wave_end", wv[1], wave);
    axr(A_WAVE_CTRL, rd, RESP_OKAY);
    chk("busy", 32'h00000000, rd[0]);
    chk("captures", 32'h00000002, n_cap);
    chk("cap_word", 32'h0000ABCD, last_w);
    wrap_up();
  end
endmodule
`default_nettype wire
